// ### shared/i2c_seq_pkg.sv
// constants, types and layouts for the two-wire master command sequencer
//============================================================
package i2c_seq_pkg;
   //============================================================
   // register offsets
   localparam logic [7:0] ADDR_TIMEOUT = 8'hc3;
   localparam logic [7:0] ADDR_SLAVE = 8'hf4;
   localparam logic [7:0] ADDR_CTRL = 8'hf5;
   localparam logic [7:0] ADDR_PERIOD = 8'hf7;
   localparam logic [7:0] RESET_VAL = 8'h00;
   //============================================================
   // field positions
   localparam int CTRL_RUN = 0;
   localparam int CTRL_START = 1;
   localparam int CTRL_STOP = 2;
   localparam int CTRL_ACK = 3;
   localparam int CTRL_HS = 4;
   localparam int CTRL_CLEAR = 7;
   localparam int STAT_BUSY = 0;
   localparam int STAT_ERROR = 1;
   localparam int STAT_IDLE = 5;
   localparam int DIR_BIT = 0;
   localparam int TO_EN_BIT = 7;
   localparam int TO_FLAG_BIT = 7;
   //============================================================
   // timing factors
   localparam int BIT_TIME_MULT = 8;
   localparam int TO_MULT = 2;
   //============================================================
   // types
   typedef enum logic [1:0] {MODE_IDLE, MODE_TX, MODE_RX} mode_e;
   typedef enum logic [1:0] {SEQ_IDLE, SEQ_START, SEQ_DATA, SEQ_STOP} seq_e;
   typedef enum logic [2:0] {STEP_NONE, STEP_START, STEP_SEND, STEP_RECV, STEP_STOP} step_kind_e;
   typedef struct packed {
      step_kind_e kind;
      logic ack;
      logic repeated;
   } step_s;
   typedef struct packed {
      logic hs;
      logic dir;
      logic ack;
      logic stop;
      logic start;
      logic run;
   } cmd_s;
   typedef struct packed {
      logic legal;
      logic start;
      logic data;
      logic rx;
      logic ack;
      logic stop;
      mode_e next;
   } plan_s;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_s;
endpackage

// ### hw/i2c_master_command_sequencer.sv
// two-wire master command decoder, step sequencer and bus timeout watchdog
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
module i2c_master_command_sequencer #(
   parameter int PERIOD_W = 8,
   parameter int SETTING_W = 7
) (
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   input wire i2c_seq_pkg::reg_req_s reg_in,
   output logic [7:0] rdata_out,
   input wire logic step_done_in,
   input wire logic step_error_in,
   output logic step_valid_out,
   output i2c_seq_pkg::step_s step_out,
   output logic [6:0] slave_addr_out,
   output logic irq_out
);
   localparam int PW = PERIOD_W + 3;
   localparam int BW = SETTING_W + 1;

   //============================================================
   // parameter check
   if (PERIOD_W != 8 || SETTING_W != 7) begin : g_chk
      $error("register fields must be 8 and 7 bits wide");
   end

   //============================================================
   // command decoder
   function automatic i2c_seq_pkg::plan_s decode(i2c_seq_pkg::mode_e m,
                                                 i2c_seq_pkg::cmd_s c);
      i2c_seq_pkg::plan_s p;
      p = '0;
      p.next = m;
      if (!c.hs) begin
         if (m == i2c_seq_pkg::MODE_IDLE) begin
            if (c.start && c.run) begin
               p.legal = !(c.dir && c.ack && c.stop);
               p.start = 1'b1;
               p.data = 1'b1;
               p.rx = c.dir;
               p.ack = c.dir & c.ack;
               p.stop = c.stop;
            end
         end else if (!c.start) begin
            if (c.stop && !c.run) begin
               p.legal = 1'b1;
               p.stop = 1'b1;
            end else if (c.run) begin
               p.data = 1'b1;
               p.rx = (m == i2c_seq_pkg::MODE_RX);
               p.ack = p.rx & c.ack;
               p.stop = c.stop;
               p.legal = !(p.rx && c.ack && c.stop);
            end
         end else if (c.run) begin
            p.legal = !(c.dir && c.ack && c.stop);
            p.start = 1'b1;
            p.data = 1'b1;
            p.rx = c.dir;
            p.ack = c.dir & c.ack;
            p.stop = c.stop;
            if (m == i2c_seq_pkg::MODE_TX && c.dir && !c.ack && c.stop) begin
               p.rx = 1'b0;
            end
         end
         if (p.stop) begin
            p.next = i2c_seq_pkg::MODE_IDLE;
         end else if (p.data) begin
            p.next = p.rx ? i2c_seq_pkg::MODE_RX : i2c_seq_pkg::MODE_TX;
         end
         if (m == i2c_seq_pkg::MODE_TX && c.start && c.dir && !c.ack && !c.stop) begin
            p.next = i2c_seq_pkg::MODE_TX;
         end
      end
      return p;
   endfunction

   //============================================================
   // register write decode
   logic wr_ctrl;
   logic wr_to;
   logic clear_q;
   logic [7:0] slave_q;
   logic [PERIOD_W-1:0] period_q;
   logic to_en_q;
   logic [SETTING_W-1:0] to_set_q;
   i2c_seq_pkg::cmd_s cmd;
   i2c_seq_pkg::plan_s plan;
   i2c_seq_pkg::plan_s plan_q;
   i2c_seq_pkg::mode_e mode_q;
   i2c_seq_pkg::seq_e seq_q;
   logic cmd_go;
   logic finish;
   logic eng_abort;
   logic to_fire;
   logic error_q;
   logic flag_q;
   logic busy;

   assign wr_ctrl = reg_in.wr && reg_in.addr == i2c_seq_pkg::ADDR_CTRL;
   assign wr_to = reg_in.wr && reg_in.addr == i2c_seq_pkg::ADDR_TIMEOUT;
   assign cmd.hs = reg_in.wdata[i2c_seq_pkg::CTRL_HS];
   assign cmd.dir = slave_q[i2c_seq_pkg::DIR_BIT];
   assign cmd.ack = reg_in.wdata[i2c_seq_pkg::CTRL_ACK];
   assign cmd.stop = reg_in.wdata[i2c_seq_pkg::CTRL_STOP];
   assign cmd.start = reg_in.wdata[i2c_seq_pkg::CTRL_START];
   assign cmd.run = reg_in.wdata[i2c_seq_pkg::CTRL_RUN];
   assign plan = decode(mode_q, cmd);
   assign busy = seq_q != i2c_seq_pkg::SEQ_IDLE;
   assign cmd_go = wr_ctrl && !reg_in.wdata[i2c_seq_pkg::CTRL_CLEAR] && !busy
                   && !clear_q && plan.legal;
   assign eng_abort = busy && step_done_in && step_error_in;
   assign finish = busy && step_done_in && !step_error_in
                   && (seq_q == i2c_seq_pkg::SEQ_STOP
                       || (seq_q == i2c_seq_pkg::SEQ_DATA && !plan_q.stop));

   //============================================================
   // software registers
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         clear_q <= 1'b0;
      end else begin
         clear_q <= wr_ctrl && reg_in.wdata[i2c_seq_pkg::CTRL_CLEAR];
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         slave_q <= i2c_seq_pkg::RESET_VAL;
         period_q <= PERIOD_W'(i2c_seq_pkg::RESET_VAL);
         to_en_q <= 1'b0;
         to_set_q <= SETTING_W'(i2c_seq_pkg::RESET_VAL);
      end else begin
         if (reg_in.wr && reg_in.addr == i2c_seq_pkg::ADDR_SLAVE) begin
            slave_q <= reg_in.wdata;
         end
         if (reg_in.wr && reg_in.addr == i2c_seq_pkg::ADDR_PERIOD) begin
            period_q <= reg_in.wdata[PERIOD_W-1:0];
         end
         if (wr_to) begin
            to_en_q <= reg_in.wdata[i2c_seq_pkg::TO_EN_BIT];
            to_set_q <= reg_in.wdata[SETTING_W-1:0];
         end
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         rdata_out <= 8'h00;
      end else if (reg_in.rd) begin
         case (reg_in.addr)
            i2c_seq_pkg::ADDR_CTRL: begin
               rdata_out <= 8'h00;
               rdata_out[i2c_seq_pkg::CTRL_CLEAR] <= clear_q;
               rdata_out[i2c_seq_pkg::STAT_IDLE] <= mode_q == i2c_seq_pkg::MODE_IDLE;
               rdata_out[i2c_seq_pkg::STAT_ERROR] <= error_q;
               rdata_out[i2c_seq_pkg::STAT_BUSY] <= busy;
            end
            i2c_seq_pkg::ADDR_TIMEOUT: rdata_out <= {flag_q, to_set_q};
            i2c_seq_pkg::ADDR_SLAVE: rdata_out <= slave_q;
            i2c_seq_pkg::ADDR_PERIOD: rdata_out <= period_q;
            default: rdata_out <= 8'h00;
         endcase
      end else begin
         rdata_out <= 8'h00;
      end
   end

   assign slave_addr_out = slave_q[7:1];

   //============================================================
   // step sequencer
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in || clear_q) begin
         seq_q <= i2c_seq_pkg::SEQ_IDLE;
         plan_q <= '0;
         step_out <= '0;
      end else if (eng_abort || to_fire) begin
         seq_q <= i2c_seq_pkg::SEQ_IDLE;
         step_out <= '0;
      end else begin
         case (seq_q)
            i2c_seq_pkg::SEQ_IDLE: begin
               if (cmd_go) begin
                  plan_q <= plan;
                  step_out.ack <= plan.ack;
                  step_out.repeated <= mode_q != i2c_seq_pkg::MODE_IDLE;
                  if (plan.start) begin
                     seq_q <= i2c_seq_pkg::SEQ_START;
                     step_out.kind <= i2c_seq_pkg::STEP_START;
                  end else if (plan.data) begin
                     seq_q <= i2c_seq_pkg::SEQ_DATA;
                     step_out.kind <= plan.rx ? i2c_seq_pkg::STEP_RECV
                                              : i2c_seq_pkg::STEP_SEND;
                  end else begin
                     seq_q <= i2c_seq_pkg::SEQ_STOP;
                     step_out.kind <= i2c_seq_pkg::STEP_STOP;
                  end
               end
            end
            i2c_seq_pkg::SEQ_START: begin
               if (step_done_in) begin
                  seq_q <= i2c_seq_pkg::SEQ_DATA;
                  step_out.kind <= plan_q.rx ? i2c_seq_pkg::STEP_RECV
                                             : i2c_seq_pkg::STEP_SEND;
               end
            end
            i2c_seq_pkg::SEQ_DATA: begin
               if (step_done_in && plan_q.stop) begin
                  seq_q <= i2c_seq_pkg::SEQ_STOP;
                  step_out.kind <= i2c_seq_pkg::STEP_STOP;
               end else if (step_done_in) begin
                  seq_q <= i2c_seq_pkg::SEQ_IDLE;
                  step_out <= '0;
               end
            end
            i2c_seq_pkg::SEQ_STOP: begin
               if (step_done_in) begin
                  seq_q <= i2c_seq_pkg::SEQ_IDLE;
                  step_out <= '0;
               end
            end
            default: seq_q <= i2c_seq_pkg::SEQ_IDLE;
         endcase
      end
   end

   assign step_valid_out = busy;

   //============================================================
   // master mode
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in || clear_q) begin
         mode_q <= i2c_seq_pkg::MODE_IDLE;
      end else if (eng_abort || to_fire) begin
         mode_q <= i2c_seq_pkg::MODE_IDLE;
      end else if (finish) begin
         mode_q <= plan_q.next;
      end
   end

   //============================================================
   // error status and interrupt
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in || clear_q) begin
         error_q <= 1'b0;
      end else if (eng_abort) begin
         error_q <= 1'b1;
      end else if (cmd_go) begin
         error_q <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= finish || eng_abort || to_fire;
      end
   end

   //============================================================
   // bus timeout watchdog
   logic [PW-1:0] presc_q;
   logic [PW-1:0] presc_lim;
   logic [BW-1:0] bt_q;
   logic [BW-1:0] bt_lim;
   logic bt_tick;

   assign presc_lim = PW'((int'(period_q) + 1) * i2c_seq_pkg::BIT_TIME_MULT - 1);
   assign bt_lim = BW'((int'(to_set_q) + 1) * i2c_seq_pkg::TO_MULT - 1);
   assign bt_tick = presc_q == presc_lim;
   assign to_fire = to_en_q && busy && bt_tick && bt_q == bt_lim;

   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in || clear_q || !to_en_q || !busy || to_fire) begin
         presc_q <= '0;
         bt_q <= '0;
      end else if (bt_tick) begin
         presc_q <= '0;
         bt_q <= bt_q + BW'(1);
      end else begin
         presc_q <= presc_q + PW'(1);
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         flag_q <= 1'b0;
      end else if (to_fire) begin
         flag_q <= 1'b1;
      end else if (clear_q) begin
         flag_q <= 1'b0;
      end
   end

   //============================================================
   // checks
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rstn_in);

   property p_idle_start_first;
      cmd_go && mode_q == i2c_seq_pkg::MODE_IDLE |=>
         step_valid_out && step_out.kind == i2c_seq_pkg::STEP_START && !step_out.repeated;
   endproperty
   a_idle_start_first: assert property (p_idle_start_first)
      else $error("idle command did not begin with a start");

   property p_data_then_stop;
      busy && !clear_q && !to_fire && seq_q == i2c_seq_pkg::SEQ_DATA && step_done_in
         && !step_error_in && plan_q.stop |=> step_out.kind == i2c_seq_pkg::STEP_STOP;
   endproperty
   a_data_then_stop: assert property (p_data_then_stop)
      else $error("stop did not follow the data step");

   property p_nop;
      wr_ctrl && !busy && !clear_q && (cmd.hs || !plan.legal) |=> !step_valid_out;
   endproperty
   a_nop: assert property (p_nop)
      else $error("no-operation command started bus activity");

   property p_hs_nop;
      wr_ctrl && cmd.hs |-> !cmd_go;
   endproperty
   a_hs_nop: assert property (p_hs_nop)
      else $error("high-speed command was accepted");

   property p_flag_sticky;
      flag_q && !clear_q |=> flag_q;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky)
      else $error("timeout flag dropped without clear");

   property p_timeout_irq;
      to_fire |=> irq_out && flag_q && !step_valid_out;
   endproperty
   a_timeout_irq: assert property (p_timeout_irq)
      else $error("timeout did not raise flag and interrupt");

   property p_done_irq;
      finish && !clear_q |=> irq_out ##1 !irq_out || $past(finish || eng_abort || to_fire);
   endproperty
   a_done_irq: assert property (p_done_irq)
      else $error("completion did not raise a one-cycle interrupt");

   property p_clear_self;
      clear_q |=> !step_valid_out && mode_q == i2c_seq_pkg::MODE_IDLE;
   endproperty
   a_clear_self: assert property (p_clear_self)
      else $error("clear did not reset the sequencer");

   property p_counter_idle;
      !busy || !to_en_q |=> bt_q == '0 && presc_q == '0;
   endproperty
   a_counter_idle: assert property (p_counter_idle)
      else $error("timeout counter ran while idle or disabled");

   property p_rx_recv;
      cmd_go && mode_q == i2c_seq_pkg::MODE_RX && !cmd.start && cmd.run |=>
         step_out.kind == i2c_seq_pkg::STEP_RECV && step_out.ack == $past(cmd.ack);
   endproperty
   a_rx_recv: assert property (p_rx_recv)
      else $error("receiver run did not receive with the set acknowledge");
endmodule

// ### verification/two_wire_engine_model.sv
// behavioural bit engine that finishes each requested step after a set delay
`timescale 1ns/1ps
module two_wire_engine_model (
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   input wire logic step_valid_in,
   input wire logic [6:0] delay_in,
   input wire logic err_in,
   output logic done_out,
   output logic error_out
);
   //============================================================
   // step timing
   logic [6:0] cnt_q;
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in || done_out || !step_valid_in) begin
         cnt_q <= 7'h00;
      end else begin
         cnt_q <= cnt_q + 7'h01;
      end
   end
   always_ff @(posedge ref_clk_in) begin
      done_out <= rstn_in && !done_out && step_valid_in && (cnt_q == delay_in);
   end
   // error only reported together with done
   assign error_out = done_out && err_in;
endmodule

// ### verification/tb_top.sv
// self-checking bench for the two-wire master command sequencer
`timescale 1ns/1ps
module tb_top;
   //============================================================
   // signals
   logic ref_clk_in = 1'b0;
   logic rstn_in = 1'b0;
   i2c_seq_pkg::reg_req_s reg_in = '0;
   logic [7:0] rdata_out;
   logic step_done_in;
   logic step_error_in;
   logic step_valid_out;
   logic irq_out;
   i2c_seq_pkg::step_s step_out;
   logic [6:0] slave_addr_out;
   logic [6:0] delay_q = 7'h00;
   logic err_q = 1'b0;
   logic [14:0] log_q = '0;
   int n_fail = 0;
   int cmp_count = 0;
   int n_irq = 0;
   int hi_cnt = 0;
   int n_step = 0;
   localparam logic [7:0] A_TO = i2c_seq_pkg::ADDR_TIMEOUT;
   localparam logic [7:0] A_SL = i2c_seq_pkg::ADDR_SLAVE;
   localparam logic [7:0] A_CT = i2c_seq_pkg::ADDR_CTRL;
   localparam logic [7:0] A_PD = i2c_seq_pkg::ADDR_PERIOD;
   localparam logic [4:0] Z = 5'h00;
   localparam logic [4:0] ST = {i2c_seq_pkg::STEP_START, 2'b00};
   localparam logic [4:0] SR = {i2c_seq_pkg::STEP_START, 2'b01};
   localparam logic [4:0] SD = {i2c_seq_pkg::STEP_SEND, 2'b00};
   localparam logic [4:0] RN = {i2c_seq_pkg::STEP_RECV, 2'b00};
   localparam logic [4:0] RA = {i2c_seq_pkg::STEP_RECV, 2'b10};
   localparam logic [4:0] SP = {i2c_seq_pkg::STEP_STOP, 2'b00};

   always #4 ref_clk_in = ~ref_clk_in;

   i2c_master_command_sequencer u_dut (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
      .reg_in(reg_in), .rdata_out(rdata_out), .step_done_in(step_done_in),
      .step_error_in(step_error_in), .step_valid_out(step_valid_out), .step_out(step_out),
      .slave_addr_out(slave_addr_out), .irq_out(irq_out));
   two_wire_engine_model u_eng (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
      .step_valid_in(step_valid_out), .delay_in(delay_q), .err_in(err_q),
      .done_out(step_done_in), .error_out(step_error_in));

   //============================================================
   // record finished steps, interrupt pulses and busy cycles
   always @(posedge ref_clk_in) begin
      if (step_valid_out === 1'b1 && step_done_in === 1'b1) begin
         log_q <= {log_q[9:0], step_out.kind,
            step_out.kind == i2c_seq_pkg::STEP_RECV && step_out.ack,
            step_out.kind == i2c_seq_pkg::STEP_START && step_out.repeated};
         n_step++;
      end
      if (irq_out === 1'b1) begin
         n_irq++;
      end
      if (step_valid_out === 1'b1) begin
         hi_cnt++;
      end
   end

   //============================================================
   // bus tasks and compare
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge ref_clk_in);
      reg_in <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(posedge ref_clk_in);
      reg_in <= '0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge ref_clk_in);
      reg_in <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge ref_clk_in);
      reg_in <= '0;
      #1 v = rdata_out;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      chk("register", 16'(exp), 16'(d));
   endtask
   task automatic run_cmd(input logic dir, input logic [7:0] ctrl, input logic [14:0] exp,
         input logic idle, input logic irq);
      int n0;
      int s0;
      int k;
      logic [14:0] msk;
      logic [7:0] d;
      wr(A_SL, {7'h2a, dir});
      s0 = n_step;
      n0 = n_irq;
      wr(A_CT, ctrl);
      repeat (2) @(posedge ref_clk_in);
      for (int i = 0; i < 3000 && step_valid_out !== 1'b0; i++) @(posedge ref_clk_in);
      repeat (2) @(posedge ref_clk_in);
      chk("busy", 16'h0000, 16'(step_valid_out));
      // only the entries logged by this command are compared
      k = n_step - s0;
      msk = ~(15'h7fff << (5 * k));
      chk("steps", 16'(exp), (k > 3) ? 16'hffff : 16'(log_q & msk));
      chk("irq", 16'(irq), 16'(n_irq - n0));
      rd(A_CT, d);
      chk("idle", 16'(idle), 16'(d[5]));
   endtask
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   //============================================================
   // scenarios
   task automatic t_reg;
      rdchk(A_TO, 8'h00);
      rdchk(A_SL, 8'h00);
      rdchk(A_CT, 8'h20);
      rdchk(A_PD, 8'h00);
      wr(8'h10, 8'hff);
      rdchk(8'h10, 8'h00);
      wr(A_PD, 8'h5a);
      rdchk(A_PD, 8'h5a);
      wr(A_TO, 8'h7f);
      rdchk(A_TO, 8'h7f);
      wr(A_TO, 8'h00);
      wr(A_SL, 8'h55);
      rdchk(A_SL, 8'h55);
      chk("slave", 16'h002a, 16'(slave_addr_out));
   endtask
   task automatic t_idle;
      delay_q <= 7'd0;
      run_cmd(0, 8'h07, {ST, SD, SP}, 1, 1);
      run_cmd(1, 8'h03, {Z, ST, RN}, 0, 1);
      run_cmd(0, 8'h05, {Z, RN, SP}, 1, 1);
      run_cmd(1, 8'h07, {ST, RN, SP}, 1, 1);
      run_cmd(1, 8'h0f, '0, 1, 0);
      run_cmd(1, 8'h0b, {Z, ST, RA}, 0, 1);
      run_cmd(1, 8'h04, {Z, Z, SP}, 1, 1);
      run_cmd(0, 8'h17, '0, 1, 0);
      run_cmd(0, 8'h01, '0, 1, 0);
   endtask
   task automatic t_tx;
      delay_q <= 7'd9;
      run_cmd(0, 8'h03, {Z, ST, SD}, 0, 1);
      run_cmd(0, 8'h01, {Z, Z, SD}, 0, 1);
      run_cmd(1, 8'h03, {Z, SR, RN}, 0, 1);
      run_cmd(0, 8'h07, {SR, SD, SP}, 1, 1);
      run_cmd(0, 8'h03, {Z, ST, SD}, 0, 1);
      run_cmd(1, 8'h07, {SR, SD, SP}, 1, 1);
      run_cmd(0, 8'h03, {Z, ST, SD}, 0, 1);
      run_cmd(0, 8'h05, {Z, SD, SP}, 1, 1);
      run_cmd(0, 8'h03, {Z, ST, SD}, 0, 1);
      run_cmd(0, 8'h04, {Z, Z, SP}, 1, 1);
      run_cmd(0, 8'h03, {Z, ST, SD}, 0, 1);
      run_cmd(1, 8'h0f, '0, 0, 0);
      run_cmd(1, 8'h0b, {Z, SR, RA}, 0, 1);
   endtask
   task automatic t_rx;
      delay_q <= 7'd3;
      run_cmd(1, 8'h09, {Z, Z, RA}, 0, 1);
      run_cmd(1, 8'h0d, '0, 0, 0);
      run_cmd(1, 8'h01, {Z, Z, RN}, 0, 1);
      run_cmd(1, 8'h03, {Z, SR, RN}, 0, 1);
      run_cmd(0, 8'h03, {Z, SR, SD}, 0, 1);
      run_cmd(1, 8'h0b, {Z, SR, RA}, 0, 1);
      run_cmd(1, 8'h07, {SR, RN, SP}, 1, 1);
   endtask
   task automatic t_error;
      err_q <= 1'b1;
      run_cmd(0, 8'h07, {Z, Z, ST}, 1, 1);
      rdchk(A_CT, 8'h22);
      err_q <= 1'b0;
      run_cmd(0, 8'h07, {ST, SD, SP}, 1, 1);
      rdchk(A_CT, 8'h20);
   endtask
   task automatic t_clear;
      delay_q <= 7'd100;
      wr(A_SL, 8'h54);
      wr(A_CT, 8'h07);
      repeat (10) @(posedge ref_clk_in);
      rdchk(A_CT, 8'h21);
      wr(A_CT, 8'h80);
      repeat (4) @(posedge ref_clk_in);
      chk("busy", 16'h0000, 16'(step_valid_out));
      rdchk(A_CT, 8'h20);
   endtask
   task automatic t_timeout;
      int h0;
      wr(A_PD, 8'h01);
      wr(A_TO, 8'h81);
      delay_q <= 7'd120;
      h0 = hi_cnt;
      run_cmd(0, 8'h07, '0, 1, 1);
      // (1+1)*2 bit times of 8*(1+1) clocks, compared exactly with no slack
      chk("timeout", 16'd64, 16'(hi_cnt - h0));
      rdchk(A_TO, 8'h81);
      delay_q <= 7'd2;
      run_cmd(0, 8'h07, {ST, SD, SP}, 1, 1);
      rdchk(A_TO, 8'h81);
      wr(A_CT, 8'h80);
      repeat (3) @(posedge ref_clk_in);
      rdchk(A_TO, 8'h01);
      // watchdog off: a long step must run to its end
      wr(A_TO, 8'h01);
      delay_q <= 7'd120;
      run_cmd(0, 8'h07, {ST, SD, SP}, 1, 1);
      rdchk(A_TO, 8'h01);
   endtask

   //============================================================
   // main sequence and watchdog
   initial begin
      repeat (12) @(posedge ref_clk_in);
      rstn_in <= 1'b1;
      t_reg;
      t_idle;
      t_tx;
      t_rx;
      t_error;
      t_clear;
      t_timeout;
      close_out;
   end
   initial begin
      #400000;
      n_fail++;
      close_out;
   end
endmodule
